/* File: design/pcc_dev_rx.sv */
// Device end: checks and corrects packet headers and verifies the footer
`timescale 1ns/1ps
`default_nettype none
`include "pcc_cfg.svh"

module pcc_dev_rx
    import pcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    pcc_link_if.rx           lk,
    output logic             hdr_valid,
    output logic [1:0]       hdr_channel,
    output logic [5:0]       hdr_type,
    output logic [15:0]      hdr_word,
    output logic             hdr_long,
    output logic             hdr_unprotected,
    output logic             pay_valid,
    output logic [7:0]       pay_data,
    output logic             pkt_done,
    output logic             crc_ok,
    input  wire logic [2:0]  flag_clear,
    output logic             flag_corrected,
    output logic             flag_uncorrectable,
    output logic             flag_checksum
);
    localparam logic [23:0] MASK [0:5] = '{`PCC_ECC_M0, `PCC_ECC_M1, `PCC_ECC_M2,
                                           `PCC_ECC_M3, `PCC_ECC_M4, `PCC_ECC_M5};

    pcc_rx_state_t state_q;
    logic [1:0]    idx_q;
    logic [23:0]   hdr_q;
    logic [15:0]   cnt_q;
    logic [15:0]   crc_q;
    logic [7:0]    foot_lo_q;
    logic          hdr_valid_q;
    logic [23:0]   hdr_out_q;
    logic          hdr_long_q;
    logic          unprot_q;
    logic          pay_valid_q;
    logic [7:0]    pay_data_q;
    logic          done_q;
    logic          crc_ok_q;
    logic [2:0]    flag_q;
    logic [7:0]    recomputed_header_parity;
    logic [23:0]   bit_hit;

    ////////////////////////////////////////////////////////////////////////
    // Header check and correction

    pcc_ecc_gen u_ecc
    (
        .hdr    (hdr_q),
        .parity (recomputed_header_parity)
    );

    wire       hdr_first = lk.valid && lk.start;
    wire       hdr_byte  = lk.valid && (state_q == RX_HDR) && (idx_q != 2'h0);
    wire       hdr_end   = hdr_byte && (idx_q == `PCC_IDX_LAST_HDR);
    wire [7:0] header_syndrome = recomputed_header_parity ^ lk.data;
    // Transmitter without parity generation sends zero
    wire       no_parity = (lk.data == `PCC_ECC_NONE);
    wire       syn_zero  = (header_syndrome == 8'h00);

    // Each header bit has its own single-error syndrome
    for (genvar i = 0; i < 24; i++)
    begin : g_hit
        assign bit_hit[i] = (header_syndrome == {2'h0, MASK[5][i], MASK[4][i], MASK[3][i],
                                                 MASK[2][i], MASK[1][i], MASK[0][i]});
    end

    wire        single   = |bit_hit;
    wire        do_fix   = !no_parity && !syn_zero && single;
    wire        multi    = !no_parity && !syn_zero && !single;
    wire [23:0] hdr_fix  = do_fix ? (hdr_q ^ bit_hit) : hdr_q;
    wire [15:0] count_in = hdr_fix[23:8];
    wire        long_in  = pcc_is_long(hdr_fix[`PCC_DI_DT]);

    ////////////////////////////////////////////////////////////////////////
    // Payload and footer decode

    wire        pay_byte  = lk.valid && !lk.start && (state_q == RX_PAY);
    wire        foot_byte = lk.valid && !lk.start && (state_q == RX_FOOT);
    wire        foot_end  = foot_byte && (idx_q == `PCC_IDX_LAST_FOOT);
    // Footer arrives low byte first
    wire [15:0] footer    = {lk.data, foot_lo_q};
    wire        crc_match = (footer == crc_q);
    wire [2:0]  flag_set  = {foot_end && !crc_match, hdr_end && multi, hdr_end && do_fix};

    assign hdr_valid          = hdr_valid_q;
    assign hdr_channel        = hdr_out_q[`PCC_DI_VC];
    assign hdr_type           = hdr_out_q[`PCC_DI_DT];
    assign hdr_word           = hdr_out_q[23:8];
    assign hdr_long           = hdr_long_q;
    assign hdr_unprotected    = unprot_q;
    assign pay_valid          = pay_valid_q;
    assign pay_data           = pay_data_q;
    assign pkt_done           = done_q;
    assign crc_ok             = crc_ok_q;
    assign flag_corrected     = flag_q[0];
    assign flag_uncorrectable = flag_q[1];
    assign flag_checksum      = flag_q[2];

    ////////////////////////////////////////////////////////////////////////
    // Packet sequence

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= RX_HDR;
            idx_q   <= 2'h0;
            hdr_q   <= 24'h000000;
            cnt_q   <= 16'h0000;
            crc_q   <= `PCC_CRC_PRESET;
            foot_lo_q <= 8'h00;
        end
        else if (hdr_first)
        begin
            // A start byte always opens a new header
            state_q     <= RX_HDR;
            idx_q       <= 2'h1;
            hdr_q[7:0]  <= lk.data;
        end
        else
        begin
            case (state_q)
                RX_HDR:
                begin
                    if (hdr_byte && !hdr_end)
                    begin
                        // First payload or count byte is the low one
                        if (idx_q == 2'h1)
                            hdr_q[15:8] <= lk.data;
                        else
                            hdr_q[23:16] <= lk.data;
                        idx_q <= idx_q + 2'h1;
                    end
                    else if (hdr_end)
                    begin
                        idx_q <= 2'h0;
                        crc_q <= `PCC_CRC_PRESET;
                        cnt_q <= count_in;
                        // Untrusted count: drop the rest of the packet
                        if (long_in && !multi)
                            state_q <= (count_in == 16'h0000) ? RX_FOOT : RX_PAY;
                    end
                end
                RX_PAY:
                begin
                    if (pay_byte)
                    begin
                        crc_q <= pcc_crc_byte(crc_q, lk.data);
                        cnt_q <= cnt_q - 16'h0001;
                        if (cnt_q == 16'h0001)
                            state_q <= RX_FOOT;
                    end
                end
                RX_FOOT:
                begin
                    if (foot_byte)
                    begin
                        foot_lo_q <= lk.data;
                        idx_q     <= idx_q + 2'h1;
                        if (foot_end)
                        begin
                            idx_q   <= 2'h0;
                            state_q <= RX_HDR;
                        end
                    end
                end
                default:
                    state_q <= RX_HDR;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // User outputs and sticky flags

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hdr_valid_q <= 1'b0;
            hdr_out_q   <= 24'h000000;
            hdr_long_q  <= 1'b0;
            unprot_q    <= 1'b0;
            pay_valid_q <= 1'b0;
            pay_data_q  <= 8'h00;
            done_q      <= 1'b0;
            crc_ok_q    <= 1'b0;
        end
        else
        begin
            hdr_valid_q <= hdr_end;
            unprot_q    <= hdr_end && no_parity;
            pay_valid_q <= pay_byte;
            done_q      <= (hdr_end && !long_in && !multi) || foot_end;
            if (hdr_end)
            begin
                hdr_out_q  <= hdr_fix;
                hdr_long_q <= long_in;
            end
            if (pay_byte)
                pay_data_q <= lk.data;
            if (foot_end)
                crc_ok_q <= crc_match;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            flag_q <= 3'h0;
        else
            flag_q <= (flag_q & ~flag_clear) | flag_set;
    end
endmodule

`default_nettype wire

/* File: design/pcc_cfg.svh */
// Constants of the packet integrity block: field positions, masks, presets
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH

// Identifier byte fields
`define PCC_DI_VC           7:6
`define PCC_DI_DT           5:0
`define PCC_DT_LOW          3:0
`define PCC_DT_LONG_A       4'h9
`define PCC_DT_LONG_B       4'hE

// Header parity subsets, bit n of a mask selects header bit n
`define PCC_ECC_M0          24'hF12CB7
`define PCC_ECC_M1          24'hF2555B
`define PCC_ECC_M2          24'h749A6D
`define PCC_ECC_M3          24'hB8E38E
`define PCC_ECC_M4          24'hDF03F0
`define PCC_ECC_M5          24'hEFFC00
`define PCC_ECC_BITS        6
`define PCC_ECC_NONE        8'h00

// Footer checksum, bit-reversed form of x^16+x^12+x^5+1
`define PCC_CRC_PRESET      16'hFFFF
`define PCC_CRC_POLY        16'h8408

// Byte positions
`define PCC_IDX_LAST_HDR    2'h3
`define PCC_IDX_LAST_FOOT   2'h1

`endif

/* File: design/pcc_pkg.sv */
// Types and the footer checksum step shared by both link ends
`include "pcc_cfg.svh"

package pcc_pkg;

    typedef enum logic [1:0] {RX_HDR, RX_PAY, RX_FOOT} pcc_rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_PAY, TX_FOOT} pcc_tx_state_t;

    // One byte into the checksum, least significant bit first
    function automatic logic [15:0] pcc_crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc;
        for (int i = 0; i < 8; i++)
        begin
            if (c[0] ^ b[i])
                c = (c >> 1) ^ `PCC_CRC_POLY;
            else
                c = c >> 1;
        end
        return c;
    endfunction

    function automatic logic pcc_is_long(input logic [5:0] dt);
        return (dt[`PCC_DT_LOW] == `PCC_DT_LONG_A) || (dt[`PCC_DT_LOW] == `PCC_DT_LONG_B);
    endfunction

endpackage

/* File: design/pcc_link_if.sv */
// Byte link between the transmitting host end and the checking device end
`timescale 1ns/1ps
`default_nettype none

interface pcc_link_if;
    logic       valid;
    logic       start;
    logic [7:0] data;

    modport tx (output valid, output start, output data);
    modport rx (input valid, input start, input data);
endinterface

`default_nettype wire

/* File: design/pcc_ecc_gen.sv */
// Header parity generator over the 24 header data bits
`timescale 1ns/1ps
`default_nettype none
`include "pcc_cfg.svh"

module pcc_ecc_gen
(
    input  wire logic [23:0] hdr,
    output logic      [7:0]  parity
);
    localparam logic [23:0] MASK [0:5] = '{`PCC_ECC_M0, `PCC_ECC_M1, `PCC_ECC_M2,
                                           `PCC_ECC_M3, `PCC_ECC_M4, `PCC_ECC_M5};

    // Odd count of ones in a subset sets its bit
    for (genvar k = 0; k < `PCC_ECC_BITS; k++)
    begin : g_par
        assign parity[k] = ^(hdr & MASK[k]);
    end

    assign parity[7:6] = 2'h0;
endmodule

`default_nettype wire

/* File: design/pcc_host_tx.sv */
// Host end: frames short and long packets with header parity, long ones also with a footer
`timescale 1ns/1ps
`default_nettype none
`include "pcc_cfg.svh"

module pcc_host_tx
    import pcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    pcc_link_if.tx           lk,
    input  wire logic        tx_req,
    input  wire logic [7:0]  tx_id,
    input  wire logic [15:0] tx_word,
    input  wire logic        tx_one_byte,
    output logic             tx_ready,
    input  wire logic        pay_valid,
    input  wire logic [7:0]  pay_data,
    output logic             pay_ready
);
    pcc_tx_state_t state_q;
    logic [1:0]    idx_q;
    logic [7:0]    id_q;
    logic [15:0]   word_q;
    logic [15:0]   cnt_q;
    logic [15:0]   crc_q;
    logic          long_q;
    logic          valid_q;
    logic          start_q;
    logic [7:0]    data_q;
    logic [7:0]    parity;

    ////////////////////////////////////////////////////////////////////////
    // Request acceptance and header byte selection

    wire        accept   = tx_req && (state_q == TX_IDLE);
    wire        req_long = pcc_is_long(tx_id[`PCC_DI_DT]);
    // Single information byte leaves the second payload byte zero
    wire [15:0] word_in  = (tx_one_byte && !req_long) ? {8'h00, tx_word[7:0]} : tx_word;
    wire        pay_take = (state_q == TX_PAY) && pay_valid;
    wire        last_hdr = (state_q == TX_HDR) && (idx_q == `PCC_IDX_LAST_HDR);
    wire        last_ft  = (state_q == TX_FOOT) && (idx_q == `PCC_IDX_LAST_FOOT);

    pcc_ecc_gen u_ecc
    (
        .hdr    ({word_q, id_q}),
        .parity (parity)
    );

    // Identifier, count low, count high, parity
    wire [7:0] hdr_byte = (idx_q == 2'h0) ? id_q :
                          (idx_q == 2'h1) ? word_q[7:0] :
                          (idx_q == 2'h2) ? word_q[15:8] : parity;
    // Footer low byte first
    wire [7:0] foot_byte = (idx_q == 2'h0) ? crc_q[7:0] : crc_q[15:8];

    assign tx_ready  = (state_q == TX_IDLE);
    assign pay_ready = (state_q == TX_PAY);
    assign lk.valid  = valid_q;
    assign lk.start  = start_q;
    assign lk.data   = data_q;

    ////////////////////////////////////////////////////////////////////////
    // Framing sequence

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= TX_IDLE;
            idx_q   <= 2'h0;
            id_q    <= 8'h00;
            word_q  <= 16'h0000;
            cnt_q   <= 16'h0000;
            crc_q   <= `PCC_CRC_PRESET;
            long_q  <= 1'b0;
            valid_q <= 1'b0;
            start_q <= 1'b0;
            data_q  <= 8'h00;
        end
        else
        begin
            valid_q <= 1'b0;
            start_q <= 1'b0;
            case (state_q)
                TX_IDLE:
                begin
                    if (accept)
                    begin
                        id_q    <= tx_id;
                        word_q  <= word_in;
                        cnt_q   <= word_in;
                        long_q  <= req_long;
                        crc_q   <= `PCC_CRC_PRESET;
                        idx_q   <= 2'h0;
                        state_q <= TX_HDR;
                    end
                end
                TX_HDR:
                begin
                    valid_q <= 1'b1;
                    start_q <= (idx_q == 2'h0);
                    data_q  <= hdr_byte;
                    idx_q   <= idx_q + 2'h1;
                    if (last_hdr)
                    begin
                        idx_q <= 2'h0;
                        if (!long_q)
                            state_q <= TX_IDLE;
                        else if (cnt_q == 16'h0000)
                            state_q <= TX_FOOT;
                        else
                            state_q <= TX_PAY;
                    end
                end
                TX_PAY:
                begin
                    if (pay_take)
                    begin
                        valid_q <= 1'b1;
                        data_q  <= pay_data;
                        crc_q   <= pcc_crc_byte(crc_q, pay_data);
                        cnt_q   <= cnt_q - 16'h0001;
                        if (cnt_q == 16'h0001)
                            state_q <= TX_FOOT;
                    end
                end
                TX_FOOT:
                begin
                    valid_q <= 1'b1;
                    data_q  <= foot_byte;
                    idx_q   <= idx_q + 2'h1;
                    if (last_ft)
                    begin
                        idx_q   <= 2'h0;
                        state_q <= TX_IDLE;
                    end
                end
                default:
                    state_q <= TX_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

/* File: tb/pcc_tb_pkg.sv */
// Reference header parity and footer checksum for the link bench
`include "pcc_cfg.svh"

package pcc_tb_pkg;

    function automatic logic [7:0] ref_ecc(input logic [23:0] d);
        return {2'b00, ^(d & `PCC_ECC_M5), ^(d & `PCC_ECC_M4), ^(d & `PCC_ECC_M3),
                ^(d & `PCC_ECC_M2), ^(d & `PCC_ECC_M1), ^(d & `PCC_ECC_M0)};
    endfunction

    // One byte, least significant bit first, reflected polynomial
    function automatic logic [15:0] ref_crc(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            r = {1'b0, r[15:1]} ^ ((r[0] ^ b[i]) ? 16'h8408 : 16'h0000);
        end
        return r;
    endfunction

endpackage

/* File: tb/pcc_link_assertions.sv */
// Wire checker for the packet link: framing, header parity and footer
`timescale 1ns/1ps
`default_nettype none

module pcc_link_chk
    import pcc_tb_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       valid,
    input wire logic       start,
    input wire logic [7:0] data
);
    logic [1:0]  hidx_q;
    logic [7:0]  id_q;
    logic [15:0] wc_q;
    logic [15:0] crc_q;
    logic [1:0]  ph_q;
    logic        fhi_q;
    wire         is_long = (id_q[3:0] == 4'h9) || (id_q[3:0] == 4'hE);

    // Tracks header, payload and footer phases of the link
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hidx_q <= 2'h0;
            id_q   <= 8'h00;
            wc_q   <= 16'h0000;
            crc_q  <= 16'hFFFF;
            ph_q   <= 2'h0;
            fhi_q  <= 1'b0;
        end
        else if (valid)
        begin
            if (start)
            begin
                hidx_q <= 2'h1;
                id_q   <= data;
                ph_q   <= 2'h0;
            end
            else if (hidx_q != 2'h0)
            begin
                hidx_q <= hidx_q + 2'h1;
                crc_q  <= 16'hFFFF;
                fhi_q  <= 1'b0;
                if (hidx_q != 2'h3)
                    wc_q <= {data, wc_q[15:8]};
                else if (is_long)
                    ph_q <= (wc_q == 16'h0000) ? 2'h2 : 2'h1;
            end
            else if (ph_q == 2'h1)
            begin
                crc_q <= ref_crc(crc_q, data);
                wc_q  <= wc_q - 16'h0001;
                if (wc_q == 16'h0001)
                    ph_q <= 2'h2;
            end
            else if (ph_q == 2'h2)
            begin
                fhi_q <= 1'b1;
                if (fhi_q)
                    ph_q <= 2'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence hdr_s;
        valid && start ##1 (valid && !start) [*3];
    endsequence

    sequence foot_lo_s;
        valid && ph_q == 2'h2 && !fhi_q;
    endsequence

    a_start_valid: assert property (start |-> valid)
        else $error("start without valid");
    a_header_run: assert property (valid && start |=> (valid && !start) [*3])
        else $error("header bytes not contiguous");
    a_parity_top: assert property (hdr_s |-> data[7:6] == 2'b00)
        else $error("parity top bits set");
    a_parity_value: assert property (hdr_s |-> data == ref_ecc({$past(data, 1), $past(data, 2), $past(data, 3)}))
        else $error("header parity wrong");
    a_footer_low: assert property (foot_lo_s |-> data == crc_q[7:0])
        else $error("footer low byte wrong");
    a_footer_high: assert property (foot_lo_s ##1 valid |-> data == crc_q[15:8])
        else $error("footer high byte wrong");
    a_footer_next: assert property (foot_lo_s |=> valid && !start)
        else $error("footer split");
    a_pay_nostart: assert property (valid && ph_q == 2'h1 |-> !start)
        else $error("packet cut short");

endmodule

`default_nettype wire

/* File: tb/tb.sv */
// Top bench: host end into device end, plus a bench-driven fault link
`timescale 1ns/1ps
`default_nettype none

module tb
    import pcc_tb_pkg::*;
;
    logic        clk, sys_rst, tx_req, tx_one, tx_ready, pay_v, pay_ready;
    logic [7:0]  tx_id, pay_d, a_pd;
    logic [15:0] tx_word, a_wd, b_wd;
    logic        a_hv, a_lg, a_pv, a_done, a_ok, a_fc, a_fu, a_fs;
    logic        b_hv, b_un, b_done, b_ok, b_fc, b_fu, b_fs;
    logic [1:0]  a_ch;
    logic [5:0]  a_ty, b_ty;
    logic [2:0]  b_clr;
    logic [7:0]  pay_q [$];
    int          err_count, total_checks;

    pcc_link_if lk_a ();
    pcc_link_if lk_b ();
    pcc_host_tx pcc_host_tx_i (.clk(clk), .sys_rst(sys_rst), .lk(lk_a), .tx_req(tx_req), .tx_id(tx_id),
        .tx_word(tx_word), .tx_one_byte(tx_one), .tx_ready(tx_ready), .pay_valid(pay_v), .pay_data(pay_d),
        .pay_ready(pay_ready));
    pcc_dev_rx pcc_dev_rx_i (.clk(clk), .sys_rst(sys_rst), .lk(lk_a), .hdr_valid(a_hv), .hdr_channel(a_ch),
        .hdr_type(a_ty), .hdr_word(a_wd), .hdr_long(a_lg), .hdr_unprotected(), .pay_valid(a_pv),
        .pay_data(a_pd), .pkt_done(a_done), .crc_ok(a_ok), .flag_clear(3'h0), .flag_corrected(a_fc),
        .flag_uncorrectable(a_fu), .flag_checksum(a_fs));
    pcc_dev_rx pcc_dev_rx_x_i (.clk(clk), .sys_rst(sys_rst), .lk(lk_b), .hdr_valid(b_hv), .hdr_channel(),
        .hdr_type(b_ty), .hdr_word(b_wd), .hdr_long(), .hdr_unprotected(b_un), .pay_valid(), .pay_data(),
        .pkt_done(b_done), .crc_ok(b_ok), .flag_clear(b_clr), .flag_corrected(b_fc),
        .flag_uncorrectable(b_fu), .flag_checksum(b_fs));
    pcc_link_chk pcc_link_chk_i (.clk(clk), .sys_rst(sys_rst), .valid(lk_a.valid), .start(lk_a.start),
        .data(lk_a.data));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic [7:0] pbyte(input int i);
        return 8'(1 + i * 37);
    endfunction

    // Bounded wait for a device pulse: 0 header, 1 packet end
    task automatic wait_sig(input int sel);
        int n;
        n = 0;
        while ((sel == 0 ? a_hv : a_done) !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(16'(n < 300), 16'h0001, "wait");
    endtask

    task automatic host_pkt(input logic [7:0] id, input logic [15:0] w, input logic one, input int n);
        int k;
        chk(tx_ready, 1'b1, "rdy");
        tx_id = id;
        tx_word = w;
        tx_one = one;
        tx_req = 1'b1;
        @(posedge clk);
        #1;
        tx_req = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            pay_v = 1'b1;
            pay_d = pbyte(i);
            k = 0;
            while (pay_ready !== 1'b1 && k < 50)
            begin
                @(posedge clk);
                #1;
                k++;
            end
            @(posedge clk);
            #1;
        end
        pay_v = 1'b0;
    endtask

    task automatic send_b(input logic [7:0] b, input logic st);
        lk_b.valid = 1'b1;
        lk_b.start = st;
        lk_b.data = b;
        @(posedge clk);
        #1;
    endtask

    // Released link shows inverted data, never the last byte
    task automatic idle_b;
        lk_b.valid = 1'b0;
        lk_b.start = 1'b0;
        lk_b.data = ~lk_b.data;
        @(posedge clk);
        #1;
    endtask

    task automatic send_hdr(input logic [23:0] h, input logic [7:0] p);
        send_b(h[7:0], 1'b1);
        send_b(h[15:8], 1'b0);
        send_b(h[23:16], 1'b0);
        send_b(p, 1'b0);
    endtask

    task automatic clr_b(input logic [2:0] m);
        b_clr = m;
        @(posedge clk);
        #1;
        b_clr = 3'h0;
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_short;
        host_pkt(8'hD5, 16'h0135, 1'b0, 0);
        wait_sig(0);
        chk(a_ch, 2'h3, "vc");
        chk(a_ty, 6'h15, "dt");
        chk(a_wd, 16'h0135, "pd");
        chk(a_lg, 1'b0, "lg");
        host_pkt(8'h05, 16'hAB10, 1'b1, 0);
        wait_sig(0);
        chk(a_wd, 16'h0010, "one");
        $display("short done, mismatches %0d", err_count);
    endtask

    task automatic t_long;
        logic [5:0] ty [8] = '{6'h09, 6'h19, 6'h29, 6'h39, 6'h0E, 6'h1E, 6'h2E, 6'h3E};
        for (int t = 0; t < 8; t++)
        begin
            pay_q.delete();
            host_pkt({t[1:0], ty[t]}, 16'(t), 1'b0, t);
            wait_sig(1);
            chk(a_ok, 1'b1, "crc");
            chk(a_lg, 1'b1, "lg");
            chk(a_wd, 16'(t), "wc");
            chk(16'(pay_q.size()), 16'(t), "cnt");
            foreach (pay_q[i]) chk(pay_q[i], pbyte(i), "pay");
        end
        chk({a_fc, a_fu, a_fs}, 3'h0, "flg");
        $display("long done, mismatches %0d", err_count);
    endtask

    task automatic t_fix;
        logic [23:0] h = 24'h567805;
        int bits [3] = '{0, 3, 23};
        foreach (bits[i])
        begin
            send_hdr(h ^ (24'h000001 << bits[i]), ref_ecc(h));
            chk({b_hv, b_fc, b_fu}, 3'h6, "fix");
            chk({b_ty, b_wd}, {6'h05, 16'h5678}, "hdr");
            idle_b;
            clr_b(3'h1);
            chk(b_fc, 1'b0, "clr");
        end
        send_hdr(h ^ 24'h000003, ref_ecc(h));
        chk({b_hv, b_done, b_fc, b_fu}, 4'h9, "multi");
        idle_b;
        send_hdr(h ^ 24'h000100, 8'h00);
        chk({b_hv, b_un, b_fc}, 3'h6, "raw");
        chk(b_wd, 16'h5679, "rawd");
        idle_b;
        clr_b(3'h2);
        chk(b_fu, 1'b0, "clr");
        $display("fix done, mismatches %0d", err_count);
    endtask

    task automatic t_crc;
        for (int g = 0; g < 2; g++)
        begin
            send_hdr(24'h000129, ref_ecc(24'h000129));
            send_b(8'h01, 1'b0);
            send_b(8'h0E, 1'b0);
            send_b(g ? 8'h1E : 8'h1F, 1'b0);
            chk({b_done, b_ok, b_fs}, {1'b1, g[0], !g[0]}, "foot");
            idle_b;
            clr_b(3'h4);
            chk(b_fs, 1'b0, "clr");
        end
        $display("crc done, mismatches %0d", err_count);
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
        if (a_pv === 1'b1)
            pay_q.push_back(a_pd);

    initial
    begin
        #50000;
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        print_verdict;
    end

    initial
    begin
        {sys_rst, tx_req, tx_one, pay_v, tx_id, pay_d, tx_word, b_clr} = {4'h8, 8'h00, 8'h00, 16'h0000, 3'h0};
        {lk_b.valid, lk_b.start, lk_b.data} = 10'h000;
        err_count = 0;
        total_checks = 0;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_short;
        t_long;
        t_fix;
        t_crc;
        print_verdict;
    end

endmodule

`default_nettype wire
